// ---- rtl/egress_limit_pkg.sv ----
// shared constants and types for the per-queue egress rate limiter
package egress_limit_pkg;
  localparam int PORTS = 5;
  localparam int FIFO_DEPTH = 8;
  // per-port queue limit, config and status register offsets, byte-wide register space
  localparam logic [7:0] P1_Q0_OFF = 8'hbb;
  localparam logic [7:0] P1_Q1_OFF = 8'hbc;
  localparam logic [7:0] P2_Q0_OFF = 8'hcb;
  localparam logic [7:0] P2_Q1_OFF = 8'hcc;
  localparam logic [7:0] P3_Q0_OFF = 8'hdb;
  localparam logic [7:0] P3_Q1_OFF = 8'hdc;
  localparam logic [7:0] P4_Q0_OFF = 8'heb;
  localparam logic [7:0] P4_Q1_OFF = 8'hec;
  localparam logic [7:0] P5_Q0_OFF = 8'hfb;
  localparam logic [7:0] P5_Q1_OFF = 8'hfc;
  localparam logic [7:0] CFG_OFF = 8'hb0;
  localparam logic [7:0] STAT_OFF = 8'hb1;
  // limit register fields
  localparam int RATE_MSB = 6;
  localparam int RSVD_BIT = 7;
  localparam logic [6:0] LIMIT_RST = 7'h00;
  // config register fields
  localparam int MODE_LSB = 0;
  localparam int RATIO_LSB = 4;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [1:0] MODE_ONE = 2'h0;
  localparam logic [1:0] MODE_TWO = 2'h1;
  localparam logic [1:0] MODE_FOUR = 2'h2;
  // shaper base tick
  localparam int TICK_NS = 1000;
  localparam int CLK_NS = 40;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic [2:0] port;
    logic queue;
    logic [7:0] data;
  } egress_word_t;
endpackage : egress_limit_pkg

// ---- rtl/egress_queue_rate_limit.sv ----
// egress queue 0/1 rate limiter with register file, fifos and scheduler
//
// Behaviour
// R1: per port, queue 0 traffic shaped by 7-bit code in bits 6:0, reset zero.
// R2: per port, queue 1 traffic shaped by its own 7-bit code, reset zero.
// R3: bit 7 of every queue limit register is reserved and reads zero.
// R4: in four-queue mode queue 0 is the lowest priority queue.
// R5: in two-queue mode queue 0 is the low priority queue of the pair.
// R6: top queue gets exact rate; lower queues scaled by the queue ratio.
// R7: rate code zero means no limiting, full line rate.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module egress_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem[rp_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : egress_fifo

module egress_queue_rate_limit (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire egress_limit_pkg::reg_req_t reg_req_i,
  output logic [7:0] rd_data_o,
  input wire logic in_valid_i,
  input wire egress_limit_pkg::egress_word_t in_word_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output egress_limit_pkg::egress_word_t out_word_o,
  input wire logic out_ready_i
);
  import egress_limit_pkg::*;

  localparam logic [7:0] Q0_OFF [PORTS] =
    '{P1_Q0_OFF, P2_Q0_OFF, P3_Q0_OFF, P4_Q0_OFF, P5_Q0_OFF};
  localparam logic [7:0] Q1_OFF [PORTS] =
    '{P1_Q1_OFF, P2_Q1_OFF, P3_Q1_OFF, P4_Q1_OFF, P5_Q1_OFF};
  localparam int EW = $bits(egress_word_t);

  logic [6:0] lim_q [PORTS][2];
  logic [7:0] cfg_q;
  logic [7:0] rd_data_q;
  logic [1:0] mode;
  logic [3:0] ratio;
  logic [4:0] tick_cnt_q;
  logic tick_q;
  logic [10:0] since_q [PORTS][2];
  logic [10:0] ivl [PORTS][2];
  logic elig [PORTS][2];
  logic stage_v_q;
  logic stage_free_q;
  egress_word_t stage_q;
  logic stage_q_sel;
  logic stage_bad;
  logic [1:0] f_in_v;
  logic [1:0] f_in_r;
  logic [1:0] f_out_v;
  logic [1:0] f_out_r;
  egress_word_t head [2];
  logic can0;
  logic can1;
  logic out_free;
  logic pop0;
  logic pop1;
  logic out_v_q;
  egress_word_t out_q;
  logic [7:0] rd_mux;

  assign mode = cfg_q[MODE_LSB +: 2];
  assign ratio = cfg_q[RATIO_LSB +: 4];
  assign rd_data_o = rd_data_q;
  assign in_ready_o = stage_free_q;
  assign out_valid_o = out_v_q;
  assign out_word_o = out_q;

  // register writes; only the 7-bit code is stored
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      for (int p = 0; p < PORTS; p++) begin
        lim_q[p][0] <= LIMIT_RST; // R1
        lim_q[p][1] <= LIMIT_RST; // R2
      end
    end else if (reg_req_i.wr) begin
      for (int p = 0; p < PORTS; p++) begin
        if (reg_req_i.addr == Q0_OFF[p]) begin
          lim_q[p][0] <= reg_req_i.wdata[RATE_MSB:0]; // R1
        end
        if (reg_req_i.addr == Q1_OFF[p]) begin
          lim_q[p][1] <= reg_req_i.wdata[RATE_MSB:0]; // R2
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cfg_q <= CFG_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == CFG_OFF) begin
      cfg_q <= reg_req_i.wdata;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    for (int p = 0; p < PORTS; p++) begin
      if (reg_req_i.addr == Q0_OFF[p]) begin
        rd_mux = {1'b0, lim_q[p][0]}; // R3
      end
      if (reg_req_i.addr == Q1_OFF[p]) begin
        rd_mux = {1'b0, lim_q[p][1]}; // R3
      end
    end
    if (reg_req_i.addr == CFG_OFF) begin
      rd_mux = cfg_q;
    end
    if (reg_req_i.addr == STAT_OFF) begin
      rd_mux = {3'h0, out_v_q, stage_v_q, 1'b0, f_out_v};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= reg_req_i.rd ? rd_mux : 8'h00;
    end
  end

  // base shaping tick
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 5'(TICK_CYC - 1));
      if (tick_cnt_q == 5'(TICK_CYC - 1)) begin
        tick_cnt_q <= '0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
      end
    end
  end

  // interval in ticks between words of one port and queue
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      for (int q = 0; q < 2; q++) begin
        if (mode == MODE_ONE || (mode == MODE_TWO && q == 1)) begin
          ivl[p][q] = {4'h0, lim_q[p][q]}; // R6
        end else begin
          ivl[p][q] = 11'(lim_q[p][q]) * (11'(ratio) + 11'h001); // R6
        end
        elig[p][q] = (lim_q[p][q] == 7'h00) || // R7
                     (since_q[p][q] >= ivl[p][q]);
      end
    end
  end

  // ticks since last word sent; saturates so long idle never wraps
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      for (int p = 0; p < PORTS; p++) begin
        since_q[p][0] <= '0;
        since_q[p][1] <= '0;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        for (int q = 0; q < 2; q++) begin
          if ((q == 0 && pop0 && head[0].port == 3'(p)) ||
              (q == 1 && pop1 && head[1].port == 3'(p))) begin
            since_q[p][q] <= '0;
          end else if (tick_q && since_q[p][q] != 11'h7ff) begin
            since_q[p][q] <= since_q[p][q] + 1'b1;
          end
        end
      end
    end
  end

  // one-word input stage keeps in_ready_o a plain flop
  assign stage_q_sel = (mode == MODE_ONE) ? 1'b0 : stage_q.queue;
  assign stage_bad = (stage_q.port >= 3'(PORTS));
  assign f_in_v[0] = stage_v_q && !stage_bad && !stage_q_sel;
  assign f_in_v[1] = stage_v_q && !stage_bad && stage_q_sel;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      stage_v_q <= 1'b0;
      stage_free_q <= 1'b1;
      stage_q <= '0;
    end else if (stage_v_q) begin
      if (stage_bad || f_in_r[stage_q_sel]) begin
        stage_v_q <= 1'b0;
        stage_free_q <= 1'b1;
      end
    end else if (in_valid_i) begin
      stage_v_q <= 1'b1;
      stage_free_q <= 1'b0;
      stage_q <= in_word_i;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_queue
    egress_fifo #(
      .WIDTH(EW),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .in_valid_i(f_in_v[g]),
      .in_ready_o(f_in_r[g]),
      .in_data_i(stage_q),
      .out_valid_o(f_out_v[g]),
      .out_ready_i(f_out_r[g]),
      .out_data_o(head[g])
    );
  end

  // strict priority; a held head word blocks its queue for all ports
  assign out_free = !out_v_q || out_ready_i;
  assign can1 = f_out_v[1] && (mode != MODE_ONE) &&
                (head[1].port < 3'(PORTS)) && elig[head[1].port][1];
  assign can0 = f_out_v[0] &&
                (head[0].port < 3'(PORTS)) && elig[head[0].port][0];
  assign pop1 = out_free && can1;
  assign pop0 = out_free && can0 && !can1; // R4 R5
  assign f_out_r[0] = pop0;
  assign f_out_r[1] = pop1;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      out_v_q <= 1'b0;
      out_q <= '0;
    end else if (out_free) begin
      out_v_q <= pop0 || pop1;
      if (pop1) begin
        out_q <= head[1];
      end else if (pop0) begin
        out_q <= head[0];
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  property p_rsvd_zero;
    reg_req_i.rd && reg_req_i.addr != CFG_OFF |=> !rd_data_o[RSVD_BIT];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // R3
    else $error("reserved bit 7 read as one");

  property p_q0_rst;
    $fell(srst_i) |-> lim_q[0][0] == 7'h00 && lim_q[4][0] == 7'h00;
  endproperty
  a_q0_rst: assert property (disable iff (1'b0) p_q0_rst) // R1
    else $error("queue 0 code not zero after reset");

  property p_q1_rst;
    $fell(srst_i) |-> lim_q[0][1] == 7'h00 && lim_q[4][1] == 7'h00;
  endproperty
  a_q1_rst: assert property (disable iff (1'b0) p_q1_rst) // R2
    else $error("queue 1 code not zero after reset");

  property p_q0_wr_rd;
    reg_req_i.wr && reg_req_i.addr == P1_Q0_OFF ##1
      reg_req_i.rd && reg_req_i.addr == P1_Q0_OFF && !reg_req_i.wr
      |=> rd_data_o == ($past(reg_req_i.wdata, 2) & 8'h7f);
  endproperty
  a_q0_wr_rd: assert property (p_q0_wr_rd) // R1
    else $error("queue 0 code readback differs from write");

  property p_q1_first;
    can1 && out_free |-> pop1 && !pop0;
  endproperty
  a_q1_first: assert property (p_q1_first) // R4
    else $error("queue 0 served ahead of eligible queue 1");

  property p_two_low;
    mode == MODE_TWO && pop0 |-> !can1;
  endproperty
  a_two_low: assert property (p_two_low) // R5
    else $error("queue 0 not low priority in two-queue mode");

  property p_top_exact;
    mode == MODE_TWO |-> ivl[2][1] == {4'h0, lim_q[2][1]} &&
      ivl[2][0] == 11'(lim_q[2][0]) * (11'(ratio) + 11'h001);
  endproperty
  a_top_exact: assert property (p_top_exact) // R6
    else $error("queue interval not as programmed");

  property p_zero_free;
    lim_q[1][0] == 7'h00 |-> elig[1][0];
  endproperty
  a_zero_free: assert property (p_zero_free) // R7
    else $error("zero code still limits traffic");

  property p_spacing;
    pop0 && head[0].port == 3'h1 && ivl[1][0] >= 11'h002
      |=> !(pop0 && head[0].port == 3'h1 &&
            ivl[1][0] >= 11'h002) [*8];
  endproperty
  a_spacing: assert property (p_spacing) // R1
    else $error("queue 0 word sent before its interval");

  c_q1_pop: cover property (pop1);
  c_q0_pop: cover property (pop0 ##1 pop0);
  c_stall: cover property (out_v_q && !out_ready_i ##1 !in_ready_o);
  c_limited: cover property (f_out_v[0] && !can0 && lim_q[1][0] != 7'h00);
endmodule : egress_queue_rate_limit

`default_nettype wire

// ---- verification/egress_queue_rate_limit_tb_top.sv ----
// self-checking bench for the egress queue rate limiter
`timescale 1ns/1ns
`default_nettype none
module egress_queue_rate_limit_tb_top;
  import egress_limit_pkg::*;
  logic clock_i;
  logic srst_i;
  reg_req_t reg_req_i;
  logic [7:0] rd_data_o;
  logic in_valid_i;
  egress_word_t in_word_i;
  logic in_ready_o;
  logic out_valid_o;
  egress_word_t out_word_o;
  logic out_ready_i;
  int fail_count;
  int checks_done;
  int cyc = 0;
  egress_word_t got_q[$];
  int got_t[$];
  logic [7:0] offs [10];

  egress_queue_rate_limit u_egress_queue_rate_limit (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .reg_req_i(reg_req_i),
    .rd_data_o(rd_data_o),
    .in_valid_i(in_valid_i),
    .in_word_i(in_word_i),
    .in_ready_o(in_ready_o),
    .out_valid_o(out_valid_o),
    .out_word_o(out_word_o),
    .out_ready_i(out_ready_i)
  );

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // handshakes are logged with their cycle so gaps can be judged later
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      got_q.push_back(out_word_o);
      got_t.push_back(cyc);
    end
  end

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_word(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    reg_req_i.wr <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic check_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    reg_req_i.rd <= 1'b0;
    #1;
    cmp_byte(rd_data_o, exp);
  endtask : check_rd

  // write then read with no gap: the read must see the new code
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
    @(posedge clock_i);
    reg_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    reg_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    reg_req_i.rd <= 1'b0;
    #1;
    cmp_byte(rd_data_o, exp);
  endtask : wr_rd

  task automatic push(input logic [2:0] p, input logic q, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    #1;
    while (in_ready_o !== 1'b1 && n < 200) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (in_ready_o !== 1'b1) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, in_ready_o, 1'b1);
    end
    @(posedge clock_i);
    in_valid_i <= 1'b1;
    in_word_i <= '{port: p, queue: q, data: d};
    @(posedge clock_i);
    in_valid_i <= 1'b0;
  endtask : push

  // queue bit is not compared: one-queue mode keeps it but sends both queues through fifo 0
  task automatic take(input logic [2:0] p, input logic [7:0] d, output int t);
    egress_word_t w;
    int n;
    n = 0;
    t = 0;
    while (got_q.size() == 0 && n < 1000) begin
      @(posedge clock_i);
      n++;
    end
    if (got_q.size() == 0) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, 11'h000, {p, d});
    end else begin
      w = got_q.pop_front();
      t = got_t.pop_front();
      cmp_word({w.port, w.data}, {p, d});
    end
  endtask : take

  task automatic prio(input logic [7:0] cfg, input logic q1_first);
    int t;
    reg_wr(CFG_OFF, cfg);
    out_ready_i <= 1'b0;
    push(3'h1, 1'b0, 8'h0a);
    push(3'h1, 1'b0, 8'h0b);
    push(3'h1, 1'b1, 8'h0c);
    repeat (10) @(posedge clock_i);
    check_rd(STAT_OFF, q1_first ? 8'h13 : 8'h11);
    out_ready_i <= 1'b1;
    take(3'h1, 8'h0a, t);
    take(3'h1, q1_first ? 8'h0c : 8'h0b, t);
    take(3'h1, q1_first ? 8'h0b : 8'h0c, t);
    $display("test priority cfg=%h done", cfg);
  endtask : prio

  // tick phase makes the gap land anywhere in one tick below the interval
  task automatic shape(input logic [7:0] cfg, input logic q,
                       input logic [6:0] code, input int iv);
    int t0;
    int t1;
    reg_wr(CFG_OFF, cfg);
    reg_wr(offs[2 + q], {1'b0, code});
    push(3'h1, q, 8'h31);
    push(3'h1, q, 8'h32);
    take(3'h1, 8'h31, t0);
    take(3'h1, 8'h32, t1);
    cmp_byte({7'h00, (t1 - t0 >= (iv - 1) * TICK_CYC &&
              t1 - t0 <= iv * TICK_CYC + 10) ? 1'b1 : 1'b0}, 8'h01);
    reg_wr(offs[2 + q], 8'h00);
    $display("test shaping cfg=%h q=%0d done", cfg, q);
  endtask : shape

  initial begin
    int t;
    srst_i = 1'b1;
    reg_req_i = '0;
    in_valid_i = 1'b0;
    in_word_i = '0;
    out_ready_i = 1'b1;
    fail_count = 0;
    checks_done = 0;
    offs = '{P1_Q0_OFF, P1_Q1_OFF, P2_Q0_OFF, P2_Q1_OFF, P3_Q0_OFF,
             P3_Q1_OFF, P4_Q0_OFF, P4_Q1_OFF, P5_Q0_OFF, P5_Q1_OFF};
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      check_rd(offs[i], {1'b0, LIMIT_RST});
    end
    check_rd(CFG_OFF, CFG_RST);
    check_rd(STAT_OFF, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 10; i++) begin
      wr_rd(offs[i], 8'hff ^ 8'(i), (8'hff ^ 8'(i)) & 8'h7f);
    end
    check_rd(8'hbf, 8'h00);
    for (int i = 0; i < 10; i++) begin
      reg_wr(offs[i], 8'h00);
    end
    $display("test register access done");
    push(3'h2, 1'b0, 8'ha5);
    take(3'h2, 8'ha5, t);
    push(3'h5, 1'b0, 8'h5a);
    repeat (30) @(posedge clock_i);
    cmp_byte(8'(got_q.size()), 8'h00);
    $display("test pass and drop done");
    prio(8'h00, 1'b0);
    prio(8'h01, 1'b1);
    prio(8'h02, 1'b1);
    prio(8'h03, 1'b1);
    shape(8'h00, 1'b0, 7'd3, 3);
    shape(8'h11, 1'b1, 7'd3, 3);
    shape(8'h11, 1'b0, 7'd3, 6);
    shape(8'h12, 1'b1, 7'd2, 4);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    complete_run();
  end
endmodule : egress_queue_rate_limit_tb_top
`default_nettype wire
